// ==== include/rbt_pkg.sv ====
// Shared constants for the data RAM self-test controller.
package rbt_pkg;

    // ****************************************************************
    // Bus and data widths
    // ****************************************************************
    localparam int RBT_AXI_AW = 8;
    localparam int RBT_AXI_DW = 32;
    localparam int RBT_RAM_AW = 15;
    localparam int RBT_RAM_DW = 16;
    localparam int RBT_CYC_W = 20;
    localparam int RBT_OSC_W = 3;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [RBT_AXI_AW-1:0] RBT_OFF_CTRL = 8'h00;
    localparam logic [RBT_AXI_AW-1:0] RBT_OFF_KEY = 8'h04;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int RBT_BIT_ARM = 0;
    localparam int RBT_BIT_FAIL = 4;
    localparam int RBT_BIT_DONE = 7;
    localparam int RBT_BIT_FINJ = 8;
    localparam logic RBT_RST_ARM = 1'b0;
    localparam logic RBT_RST_FAIL = 1'b0;
    localparam logic RBT_RST_DONE = 1'b0;
    localparam logic RBT_RST_FINJ = 1'b0;
    localparam logic [RBT_OSC_W-1:0] RBT_RST_OSC = 3'h0;

    // ****************************************************************
    // Unlock keys and answer codes
    // ****************************************************************
    localparam logic [7:0] RBT_KEY_FIRST = 8'h55;
    localparam logic [7:0] RBT_KEY_SECOND = 8'haa;
    localparam logic [1:0] RBT_RESP_OKAY = 2'h0;
    localparam logic [1:0] RBT_RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Test sizing and patterns
    // ****************************************************************
    localparam int RBT_TEST_CYCLES = 528384;
    localparam int RBT_RAM_WORDS = 24576;
    localparam logic [RBT_RAM_DW-1:0] RBT_PAT_A = 16'h55aa;

endpackage

// ==== core/rbt_march.sv ====
// Word-by-word write and read-back engine that sweeps the data RAM.
`timescale 1ns/1ps
`default_nettype none

module rbt_march #(
    parameter int unsigned RAM_WORDS = rbt_pkg::RBT_RAM_WORDS,
    parameter int unsigned TEST_CYCLES = rbt_pkg::RBT_TEST_CYCLES
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic start, // One-cycle start pulse
    input wire logic [rbt_pkg::RBT_RAM_DW-1:0] ram_rdata, // Read data, one cycle late
    output logic busy, // Sweep in progress
    output logic finish, // One-cycle end pulse
    output logic mismatch, // Sticky compare failure
    output logic [rbt_pkg::RBT_RAM_AW-1:0] ram_addr, // RAM word address
    output logic ram_en, // RAM access enable
    output logic ram_we, // RAM write enable
    output logic [rbt_pkg::RBT_RAM_DW-1:0] ram_wdata // RAM write data
);
    import rbt_pkg::*;

    typedef enum logic [2:0] {
        PH_IDLE, PH_WR_A, PH_RD_A, PH_CMP_A, PH_WR_B, PH_RD_B, PH_CMP_B, PH_PAD
    } rbt_phase_t;

    rbt_phase_t phase, next_phase;
    logic [RBT_CYC_W-1:0] cyc, next_cyc;
    logic [RBT_RAM_AW-1:0] next_addr;
    logic next_mismatch, next_finish, next_busy, next_en, next_we;
    logic [RBT_RAM_DW-1:0] next_wdata;

    // Address-dependent data catches decoder faults as well as stuck cells.
    function automatic logic [RBT_RAM_DW-1:0] rbt_pat(input logic [RBT_RAM_AW-1:0] a,
                                                      input logic inv);
        logic [RBT_RAM_DW-1:0] p;
        p = RBT_PAT_A ^ {1'b0, a};
        return inv ? ~p : p;
    endfunction

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        next_phase = phase;
        next_addr = ram_addr;
        next_mismatch = mismatch;
        next_finish = 1'b0;
        next_cyc = (phase == PH_IDLE) ? cyc : cyc + 1'b1;
        unique case (phase)
            PH_IDLE: begin
                if (start) begin
                    next_phase = PH_WR_A;
                    next_addr = '0;
                    next_mismatch = 1'b0;
                    next_cyc = '0;
                end
            end
            PH_WR_A: next_phase = PH_RD_A;
            PH_RD_A: next_phase = PH_CMP_A;
            PH_CMP_A: begin
                if (ram_rdata != rbt_pat(ram_addr, 1'b0)) begin
                    next_mismatch = 1'b1;
                end
                next_phase = PH_WR_B;
            end
            PH_WR_B: next_phase = PH_RD_B;
            PH_RD_B: next_phase = PH_CMP_B;
            PH_CMP_B: begin
                if (ram_rdata != rbt_pat(ram_addr, 1'b1)) begin
                    next_mismatch = 1'b1;
                end
                if (ram_addr == RBT_RAM_AW'(RAM_WORDS - 1)) begin
                    next_phase = PH_PAD;
                end else begin
                    next_addr = ram_addr + 1'b1;
                    next_phase = PH_WR_A;
                end
            end
            PH_PAD: begin
                // Padding fixes the run length.
                if (cyc >= RBT_CYC_W'(TEST_CYCLES - 1)) begin
                    next_phase = PH_IDLE;
                    next_finish = 1'b1;
                end
            end
        endcase
        next_busy = (next_phase != PH_IDLE);
        next_we = (next_phase == PH_WR_A) || (next_phase == PH_WR_B);
        next_en = next_we || (next_phase == PH_RD_A) || (next_phase == PH_RD_B);
        next_wdata = rbt_pat(next_addr, next_phase == PH_WR_B);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= PH_IDLE;
            cyc <= '0;
            ram_addr <= '0;
            mismatch <= 1'b0;
            finish <= 1'b0;
            busy <= 1'b0;
            ram_en <= 1'b0;
            ram_we <= 1'b0;
            ram_wdata <= '0;
        end else begin
            phase <= next_phase;
            cyc <= next_cyc;
            ram_addr <= next_addr;
            mismatch <= next_mismatch;
            finish <= next_finish;
            busy <= next_busy;
            ram_en <= next_en;
            ram_we <= next_we;
            ram_wdata <= next_wdata;
        end
    end

endmodule

`default_nettype wire

// ==== core/rbt_top.sv ====
// Data RAM self-test controller with protected control register on AXI4-Lite.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Test every RAM word, report only pass/fail.
// - Done bit 7 set after test, else zero.
// - Fail bit 4 read-only, one means failed.
// - Pass does not guarantee full coverage.
// - Start-up test only on power-on, disable zero.
// - Start-up test after config, before code runs.
// - Test uses selected clock, kept for code.
// - Test lasts exactly 528384 instruction cycles.
// - Run-time test wipes RAM; software prepares reset.
// - Arm bit 0 runs test next reset.
// - Arm bit self-clears when test completes.
// - Control writes need unlock; one bit each.
// - Fault inject bit 8 forces fail result.
// - Fault inject bit cleared only by power-on; an unlocked control write of zero also clears it.
// - Bits 15-9, 6-5, 3-1 read zero.
module rbt_top #(
    parameter int unsigned RAM_WORDS = rbt_pkg::RBT_RAM_WORDS,
    parameter int unsigned TEST_CYCLES = rbt_pkg::RBT_TEST_CYCLES
) (
    input wire logic aclk, // System clock, 200 MHz
    input wire logic aresetn, // Device reset, any cause, low
    input wire logic por_n, // Power-on reset, low
    input wire logic config_loaded, // Configuration words loaded
    input wire logic startup_test_disable, // Config bit, one skips power-on test
    input wire logic [rbt_pkg::RBT_OSC_W-1:0] oscillator_select_config, // Clock choice
    input wire logic [rbt_pkg::RBT_AXI_AW-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [rbt_pkg::RBT_AXI_DW-1:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [rbt_pkg::RBT_AXI_AW-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [rbt_pkg::RBT_AXI_DW-1:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [rbt_pkg::RBT_RAM_DW-1:0] ram_rdata, // RAM read data
    output logic [rbt_pkg::RBT_RAM_AW-1:0] ram_addr, // RAM word address
    output logic ram_en, // RAM access enable
    output logic ram_we, // RAM write enable
    output logic [rbt_pkg::RBT_RAM_DW-1:0] ram_wdata, // RAM write data
    output logic test_active, // Test owns the RAM
    output logic cpu_release, // Code may start executing
    output logic [rbt_pkg::RBT_OSC_W-1:0] clock_source_sel // Held clock choice
);
    import rbt_pkg::*;

    typedef enum logic [1:0] {
        ST_CFG, ST_TEST, ST_RUN
    } rbt_state_t;

    typedef enum logic [1:0] {
        UL_NONE, UL_HALF, UL_OPEN
    } rbt_unlock_t;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    rbt_state_t state, next_state;
    rbt_unlock_t unlock, next_unlock;

    logic self_test_arm_bit, next_arm;
    logic fault_inject_bit, next_finj;
    logic por_pending, next_por_pending;
    logic self_test_done_flag, next_done;
    logic self_test_fail_flag, next_fail;
    logic next_cpu_release;
    logic [RBT_OSC_W-1:0] next_clk_sel;
    logic start_pulse, next_start;

    logic aw_held, next_aw_held;
    logic [RBT_AXI_AW-1:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [RBT_AXI_DW-1:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_arready;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [RBT_AXI_DW-1:0] next_rdata;

    logic wr_fire, wr_ctrl, wr_key, ctrl_ok, set_arm, set_finj;
    logic eng_busy, eng_finish, eng_mismatch;
    logic [RBT_AXI_DW-1:0] ctrl_word;

    // ****************************************************************
    // RAM sweep engine
    // ****************************************************************
    rbt_march #(
        .RAM_WORDS(RAM_WORDS),
        .TEST_CYCLES(TEST_CYCLES)
    ) u_march (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start_pulse),
        .ram_rdata(ram_rdata),
        .busy(eng_busy),
        .finish(eng_finish),
        .mismatch(eng_mismatch),
        .ram_addr(ram_addr),
        .ram_en(ram_en),
        .ram_we(ram_we),
        .ram_wdata(ram_wdata)
    );

    // ****************************************************************
    // Register write decode
    // ****************************************************************
    always_comb begin
        wr_fire = aw_held && w_held && !s_axi_bvalid;
        wr_ctrl = wr_fire && (aw_addr[RBT_AXI_AW-1:2] == RBT_OFF_CTRL[RBT_AXI_AW-1:2]);
        wr_key = wr_fire && (aw_addr[RBT_AXI_AW-1:2] == RBT_OFF_KEY[RBT_AXI_AW-1:2]);
        set_arm = w_strb[0] && w_data[RBT_BIT_ARM] && !self_test_arm_bit;
        set_finj = w_strb[1] && w_data[RBT_BIT_FINJ] && !fault_inject_bit;
        // An unlock allows one bit to be set; a write setting two does nothing.
        ctrl_ok = wr_ctrl && (unlock == UL_OPEN) && !(set_arm && set_finj);
    end

    // ****************************************************************
    // Unlock sequencer
    // ****************************************************************
    always_comb begin
        next_unlock = unlock;
        if (wr_fire) begin
            // Any write other than the next key step spends or breaks the sequence.
            next_unlock = UL_NONE;
            if (wr_key && w_strb[0]) begin
                if (w_data[7:0] == RBT_KEY_FIRST) begin
                    next_unlock = UL_HALF;
                end else if (unlock == UL_HALF && w_data[7:0] == RBT_KEY_SECOND) begin
                    next_unlock = UL_OPEN;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlock <= UL_NONE;
        end else begin
            unlock <= next_unlock;
        end
    end

    // ****************************************************************
    // Bits kept across device resets
    // ****************************************************************
    always_comb begin
        next_arm = self_test_arm_bit;
        next_finj = fault_inject_bit;
        next_por_pending = por_pending;
        if (eng_finish) begin
            next_arm = 1'b0;
        end
        if (ctrl_ok && w_strb[0]) begin
            next_arm = w_data[RBT_BIT_ARM];
        end
        if (ctrl_ok && w_strb[1]) begin
            next_finj = w_data[RBT_BIT_FINJ];
        end
        if (state == ST_CFG && config_loaded) begin
            next_por_pending = 1'b0;
        end
    end

    // Only power-on resets these, so an armed test survives the launching reset.
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            self_test_arm_bit <= RBT_RST_ARM;
            fault_inject_bit <= RBT_RST_FINJ;
            por_pending <= 1'b1;
        end else begin
            self_test_arm_bit <= next_arm;
            fault_inject_bit <= next_finj;
            por_pending <= next_por_pending;
        end
    end

    // ****************************************************************
    // Start-up and completion control
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_start = 1'b0;
        next_done = self_test_done_flag;
        next_fail = self_test_fail_flag;
        next_cpu_release = cpu_release;
        next_clk_sel = clock_source_sel;
        if (ctrl_ok && w_strb[0] && !w_data[RBT_BIT_DONE]) begin
            next_done = 1'b0;
        end
        unique case (state)
            ST_CFG: begin
                if (config_loaded) begin
                    // Clock choice is frozen here and kept once code runs.
                    next_clk_sel = oscillator_select_config;
                    if ((por_pending && !startup_test_disable) || self_test_arm_bit) begin
                        next_state = ST_TEST;
                        next_start = 1'b1;
                    end else begin
                        next_state = ST_RUN;
                        next_cpu_release = 1'b1;
                    end
                end
            end
            ST_TEST: begin
                if (eng_finish) begin
                    next_state = ST_RUN;
                    next_cpu_release = 1'b1;
                    // A pass here only means no mismatch was seen.
                    next_fail = eng_mismatch || fault_inject_bit;
                end
            end
            ST_RUN: begin
            end
        endcase
        if (eng_finish) begin
            next_done = 1'b1;
        end
    end

    // Done and fail describe the last reset sequence, so every reset clears them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_CFG;
            start_pulse <= 1'b0;
            self_test_done_flag <= RBT_RST_DONE;
            self_test_fail_flag <= RBT_RST_FAIL;
            cpu_release <= 1'b0;
            clock_source_sel <= RBT_RST_OSC;
            test_active <= 1'b0;
        end else begin
            state <= next_state;
            start_pulse <= next_start;
            self_test_done_flag <= next_done;
            self_test_fail_flag <= next_fail;
            cpu_release <= next_cpu_release;
            clock_source_sel <= next_clk_sel;
            test_active <= (next_state == ST_TEST);
        end
    end

    // ****************************************************************
    // Control register read image
    // ****************************************************************
    always_comb begin
        ctrl_word = '0;
        ctrl_word[RBT_BIT_ARM] = self_test_arm_bit;
        ctrl_word[RBT_BIT_FAIL] = self_test_fail_flag;
        ctrl_word[RBT_BIT_DONE] = self_test_done_flag;
        ctrl_word[RBT_BIT_FINJ] = fault_inject_bit;
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            // A locked control write is dropped silently but still answers OKAY.
            next_bresp = (wr_ctrl || wr_key) ? RBT_RESP_OKAY : RBT_RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RBT_RESP_OKAY;
            if (s_axi_araddr[RBT_AXI_AW-1:2] == RBT_OFF_CTRL[RBT_AXI_AW-1:2]) begin
                next_rdata = ctrl_word;
            end else if (s_axi_araddr[RBT_AXI_AW-1:2] == RBT_OFF_KEY[RBT_AXI_AW-1:2]) begin
                next_rdata = '0;
            end else begin
                next_rdata = '0;
                next_rresp = RBT_RESP_SLVERR;
            end
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RBT_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RBT_RESP_OKAY;
            s_axi_rdata <= '0;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// ==== verif/rbt_ram_model.sv ====
// Data RAM model with a commanded stuck bit.
`timescale 1ns/1ps
`default_nettype none
module rbt_ram_model (
    input wire logic aclk, // clock
    input wire logic [rbt_pkg::RBT_RAM_AW-1:0] ram_addr, // word address
    input wire logic ram_en, // access enable
    input wire logic ram_we, // write enable
    input wire logic [rbt_pkg::RBT_RAM_DW-1:0] ram_wdata, // write data
    input wire logic stuck, // corrupt bit 0 of reads
    output logic [rbt_pkg::RBT_RAM_DW-1:0] ram_rdata // read data, one cycle late
);
    import rbt_pkg::*;
    logic [RBT_RAM_DW-1:0] mem [0:255];
    // Idle cycles show the inverse so a late sample is caught.
    always_ff @(posedge aclk) begin
        ram_rdata <= (ram_en && !ram_we) ? mem[ram_addr[7:0]] ^ {15'h0, stuck} : ~ram_rdata;
        if (ram_en && ram_we)
            mem[ram_addr[7:0]] <= ram_wdata;
    end
endmodule
`default_nettype wire

// ==== verif/rbt_props.sv ====
// Bus handshake and test sequencing checks.
`timescale 1ns/1ps
`default_nettype none
module rbt_props #(
    parameter int unsigned TEST_CYCLES = rbt_pkg::RBT_TEST_CYCLES
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, low
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic ram_en, // RAM enable
    input wire logic test_active, // test owns RAM
    input wire logic cpu_release, // code may run
    input wire logic [rbt_pkg::RBT_OSC_W-1:0] clock_source_sel // clock choice
);
    import rbt_pkg::*;
    logic [19:0] run_len;
    logic [19:0] next_run_len;
    always_comb next_run_len = (!aresetn || !test_active) ? 20'h0 : run_len + 20'h1;
    always_ff @(posedge aclk) run_len <= next_run_len;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
    sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
    sequence test_ends; $fell(test_active); endsequence
    b_hold_a: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (r_wait |=> s_axi_rvalid)
        else $error("read data dropped early");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    test_len_a: assert property (test_ends |-> cpu_release && run_len >= TEST_CYCLES
        && run_len <= TEST_CYCLES + 2) else $error("test length or release wrong");
    hold_code_a: assert property (test_active |-> !cpu_release)
        else $error("code released during test");
    ram_owner_a: assert property (ram_en |-> test_active)
        else $error("RAM touched outside a test");
    clock_kept_a: assert property (cpu_release |=> $stable(clock_source_sel))
        else $error("clock choice changed while running");
    release_stays_a: assert property (cpu_release |=> cpu_release)
        else $error("release dropped without reset");
endmodule
bind rbt_top rbt_props #(.TEST_CYCLES(TEST_CYCLES)) u_props (.aclk, .aresetn, .s_axi_awready,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .ram_en, .test_active, .cpu_release, .clock_source_sel);
`default_nettype wire

// ==== verif/rbt_tb_top.sv ====
// Self-checking bench for the self-test controller.
`timescale 1ns/1ps
`default_nettype none
module rbt_tb_top;
    import rbt_pkg::*;
    logic aclk = 0, aresetn = 0, por_n = 0, config_loaded = 0, startup_test_disable = 1, stuck = 0;
    logic [RBT_OSC_W-1:0] oscillator_select_config = 3'h0, clock_source_sel;
    logic [RBT_AXI_AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [RBT_AXI_DW-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [RBT_RAM_DW-1:0] ram_rdata, ram_wdata;
    logic [RBT_RAM_AW-1:0] ram_addr;
    logic ram_en, ram_we, test_active, cpu_release;
    logic [33:0] expq [$];
    int failures = 0, n_checks = 0, tn = 0;
    rbt_top #(.RAM_WORDS(8), .TEST_CYCLES(64)) u_dut (.aclk, .aresetn, .por_n, .config_loaded,
        .startup_test_disable, .oscillator_select_config, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ram_rdata, .ram_addr, .ram_en,
        .ram_we, .ram_wdata, .test_active, .cpu_release, .clock_source_sel);
    rbt_ram_model u_ram (.aclk, .ram_addr, .ram_en, .ram_we, .ram_wdata, .stuck, .ram_rdata);
    initial forever #2.5 aclk = ~aclk;
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tend();
        tn++;
        $display("test %0d finished", tn);
    endtask
    // Software reset keeps por_n high.
    task automatic boot(input logic por, input logic dis);
        logic [RBT_OSC_W-1:0] osc;
        osc = 3'($urandom);
        aresetn <= 1'b0; por_n <= !por; config_loaded <= 1'b0;
        startup_test_disable <= dis; oscillator_select_config <= osc;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1; por_n <= 1'b1;
        @(posedge aclk);
        config_loaded <= 1'b1;
        for (int i = 0; i < 200 && !cpu_release; i++) @(posedge aclk);
        @(posedge aclk);
        chk({31'h0, clock_source_sel}, {31'h0, osc});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(s_axi_bresp, {a > 8'h04, 1'b0});
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        expq.push_back(e);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    task automatic unlock();
        wr(RBT_OFF_KEY, {24'h0, RBT_KEY_FIRST});
        wr(RBT_OFF_KEY, {24'h0, RBT_KEY_SECOND});
    endtask
    always @(posedge aclk)
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'hd4021600));
        boot(1'b1, 1'b1);
        rd(RBT_OFF_CTRL, 34'h0);
        rd(RBT_OFF_KEY, 34'h0);
        rd({6'($urandom_range(63, 2)), 2'b00}, {RBT_RESP_SLVERR, 32'h0});
        tend();
        boot(1'b1, 1'b0);
        rd(RBT_OFF_CTRL, 34'h80);
        wr(RBT_OFF_CTRL, 32'h1);
        unlock();
        wr(8'h08, 32'h0);
        wr(RBT_OFF_CTRL, 32'h1);
        unlock();
        wr(RBT_OFF_CTRL, 32'h101);
        rd(RBT_OFF_CTRL, 34'h80);
        unlock();
        wr(RBT_OFF_CTRL, {16'h0, 16'($urandom) & 16'hfe6e | 16'h1});
        rd(RBT_OFF_CTRL, 34'h1);
        tend();
        boot(1'b0, 1'b1);
        rd(RBT_OFF_CTRL, 34'h80);
        unlock();
        wr(RBT_OFF_CTRL, 32'h1);
        unlock();
        wr(RBT_OFF_CTRL, 32'h101);
        boot(1'b0, 1'b1);
        rd(RBT_OFF_CTRL, 34'h190);
        boot(1'b0, 1'b1);
        rd(RBT_OFF_CTRL, 34'h100);
        tend();
        stuck <= 1'b1;
        boot(1'b1, 1'b0);
        rd(RBT_OFF_CTRL, 34'h90);
        tend();
        end_of_test();
    end
endmodule
`default_nettype wire
